// ### logic/tcd_touch_ctrl.sv
// Purpose: Decode the touch command byte into panel switches, converter
//          selection, power state and the pen interrupt pin.
// Assumes: SCL is a clock port; frame qualifiers arrive in SCL domain.
// Notes:   Clock enable freezes the system-clock domain only.
// Overview of operation
// - Command bits sampled on SCL rise, MSB first
// - Bit 7 picks accelerate/axis versus sleep
// - Bits 6-4 pick inputs and driver switches
// - Bit 1 zero gives 12-bit, one 8-bit
// - Bit 2 sets auto power-down or converter on
// - Selector x10 first pressure: X-, Y+ on
// - Selector x11 second pressure: X-, Y+ on
// - Auto mode powers converter only while converting
// - Auto mode leaves only Y- switch closed unless converting or accelerating
// - Auto mode pen detect on except conversion
// - PD one with axis keeps power on
// - PD one forces pen interrupt low
// - Accelerate closes switches at falling edge 18
// - Accelerate sampling happens in later read
// - Sleep opens panel; bit 1 picks irq drive
// - Sleep entry and exit at rising edge 16
// - Results MSB first, 12 bits (8 in 8-bit mode) then zeros
`timescale 1ns/1ps
module tcd_touch_ctrl (
    // System clock
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Serial link
    input wire logic scl,
    input wire logic sda_in,
    input wire logic write_frame,
    input wire logic read_frame,
    // Panel sense and converter
    input wire logic pen_touched,
    input wire logic [tcd_pkg::RES_W-1:0] adc_result,
    input wire logic adc_done,
    // Panel driver switches
    output logic x_pos_plate_on,
    output logic x_neg_plate_on,
    output logic y_pos_plate_on,
    output logic y_neg_plate_on,
    // Converter control
    output tcd_pkg::tcd_node_t conv_input_pos,
    output tcd_pkg::tcd_node_t conv_input_neg,
    output tcd_pkg::tcd_node_t ref_pos,
    output tcd_pkg::tcd_node_t ref_neg,
    output logic conv_power,
    output logic resolution_8bit,
    output logic [tcd_pkg::WORD_W-1:0] read_word,
    // Pen interrupt pin, active low
    output logic pen_touch_irq_n_out,
    output logic pen_touch_irq_n_oe
);
    import tcd_pkg::*;

    logic [CMD_W-1:0] sleep_byte;
    logic [CMD_W-1:0] cmd_byte;
    logic sleep_tgl;
    logic apply_tgl;
    logic link_busy;

    tcd_link_capture u_link (
        .scl(scl),
        .srst(srst),
        .write_frame(write_frame),
        .read_frame(read_frame),
        .sda_in(sda_in),
        .sleep_byte(sleep_byte),
        .sleep_tgl(sleep_tgl),
        .cmd_byte(cmd_byte),
        .apply_tgl(apply_tgl),
        .conv_busy(link_busy)
    );

    // Crossing: toggles and levels through two flops each
    logic [3:0] sync_meta;
    logic [3:0] sync_q;
    logic sleep_prev;
    logic apply_prev;
    logic busy_prev;
    logic sleep_evt;
    logic apply_evt;
    logic busy;
    logic pen_s;
    logic conv_end;

    always_ff @(posedge clk) begin
        if (srst) begin
            sync_meta <= '0;
            sync_q <= '0;
        end else if (ce) begin
            sync_meta <= {pen_touched, link_busy, apply_tgl, sleep_tgl};
            sync_q <= sync_meta;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sleep_prev <= 1'b0;
            apply_prev <= 1'b0;
            busy_prev <= 1'b0;
        end else if (ce) begin
            sleep_prev <= sync_q[0];
            apply_prev <= sync_q[1];
            busy_prev <= sync_q[2];
        end
    end

    assign sleep_evt = sync_q[0] ^ sleep_prev;
    assign apply_evt = sync_q[1] ^ apply_prev;
    assign busy = sync_q[2];
    assign pen_s = sync_q[3];
    assign conv_end = busy_prev & ~busy;

    // Sleep state machine
    tcd_mode_t mode;
    logic sleep_hiz;

    always_ff @(posedge clk) begin
        if (srst) begin
            mode <= ST_NORMAL;
            sleep_hiz <= 1'b0;
        end else if (ce && sleep_evt) begin
            case (mode)
                ST_NORMAL: begin
                    if (tcd_is_sleep(sleep_byte)) begin
                        mode <= ST_SLEEP;
                        sleep_hiz <= sleep_byte[BIT_RES];
                    end
                end
                ST_SLEEP: begin
                    if (sleep_byte[BIT_CLASS]) begin
                        mode <= ST_NORMAL;
                    end else if (tcd_is_sleep(sleep_byte)) begin
                        sleep_hiz <= sleep_byte[BIT_RES];
                    end
                end
                default: mode <= ST_NORMAL;
            endcase
        end
    end

    // Command fields; bits 3 and 0 are never stored
    logic [SEL_W-1:0] sel;
    logic pd;
    logic res;
    logic accel_hold;

    always_ff @(posedge clk) begin
        if (srst) begin
            sel <= RST_SEL;
            pd <= RST_PD;
            res <= RST_RES;
        end else if (ce && apply_evt && cmd_byte[BIT_CLASS]) begin
            sel <= cmd_byte[BIT_SEL_HI:BIT_SEL_LO];
            pd <= cmd_byte[BIT_PD];
            res <= cmd_byte[BIT_RES];
        end
    end

    // Accelerate holds the drive from edge 18 until conversion ends
    always_ff @(posedge clk) begin
        if (srst) begin
            accel_hold <= 1'b0;
        end else if (ce) begin
            if (apply_evt && cmd_byte[BIT_CLASS]) begin
                accel_hold <= ~cmd_byte[BIT_SEL_HI];
            end else if (conv_end) begin
                accel_hold <= 1'b0;
            end
        end
    end

    // Output decode
    logic drive_on;
    logic axis_sel;
    logic [3:0] next_sw;
    logic next_power;
    logic next_irq_out;
    logic next_irq_oe;
    tcd_node_t next_pos;
    tcd_node_t next_neg;
    tcd_node_t next_ref_pos;
    tcd_node_t next_ref_neg;

    assign axis_sel = (sel == SEL_X_AXIS) || (sel == SEL_Y_AXIS);
    assign drive_on = busy | accel_hold | pd;

    always_comb begin
        if (mode == ST_SLEEP) begin
            next_sw = SW_OPEN;
        end else if (drive_on) begin
            next_sw = tcd_switches(sel[1:0]);
        end else begin
            next_sw = SW_IDLE;
        end
    end

    // Converter powered only while converting, or held by PD with an axis
    always_comb begin
        next_power = (mode == ST_NORMAL) &&
                     (busy || (pd && axis_sel));
    end

    always_comb begin
        next_neg = NODE_XN;
        next_ref_neg = NODE_XN;
        next_ref_pos = NODE_YP;
        next_pos = NODE_XP;
        case (sel[1:0])
            PAIR_X: begin
                next_pos = NODE_YP;
                next_ref_pos = NODE_XP;
            end
            PAIR_Y: begin
                next_neg = NODE_YN;
                next_ref_neg = NODE_YN;
            end
            PAIR_Z1: next_pos = NODE_XP;
            PAIR_Z2: next_pos = NODE_YN;
            default: next_pos = NODE_XP;
        endcase
    end

    // Pin is released only in high-impedance sleep
    always_comb begin
        next_irq_oe = 1'b1;
        next_irq_out = 1'b1;
        if (mode == ST_SLEEP) begin
            next_irq_oe = ~sleep_hiz;
        end else if (pd) begin
            next_irq_out = 1'b0;
        end else if (busy) begin
            next_irq_out = 1'b0;
        end else begin
            next_irq_out = ~pen_s;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            {x_pos_plate_on, x_neg_plate_on} <= 2'h0;
            {y_pos_plate_on, y_neg_plate_on} <= 2'h0;
            conv_power <= 1'b0;
            resolution_8bit <= RST_RES;
            pen_touch_irq_n_out <= 1'b1;
            pen_touch_irq_n_oe <= 1'b1;
        end else if (ce) begin
            {x_pos_plate_on, x_neg_plate_on} <= next_sw[3:2];
            {y_pos_plate_on, y_neg_plate_on} <= next_sw[1:0];
            conv_power <= next_power;
            resolution_8bit <= res;
            pen_touch_irq_n_out <= next_irq_out;
            pen_touch_irq_n_oe <= next_irq_oe;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            conv_input_pos <= NODE_YP;
            conv_input_neg <= NODE_XN;
            ref_pos <= NODE_XP;
            ref_neg <= NODE_XN;
        end else if (ce) begin
            conv_input_pos <= next_pos;
            conv_input_neg <= next_neg;
            ref_pos <= next_ref_pos;
            ref_neg <= next_ref_neg;
        end
    end

    // Left-justified result; 8-bit mode keeps only the upper byte
    always_ff @(posedge clk) begin
        if (srst) begin
            read_word <= '0;
        end else if (ce && adc_done) begin
            if (res) begin
                read_word <= {adc_result[RES_W-1:RES_W-BYTE_W],
                              BYTE_ZERO};
            end else begin
                read_word <= {adc_result, PAD_ZERO};
            end
        end
    end

    property p_sleep_open;
        @(posedge clk) disable iff (srst)
        (ce && mode == ST_SLEEP) |=> !x_pos_plate_on && !x_neg_plate_on &&
            !y_pos_plate_on && !y_neg_plate_on;
    endproperty
    a_sleep_open: assert property (p_sleep_open)
        else $error("panel not open in sleep");

    property p_idle_yn;
        @(posedge clk) disable iff (srst)
        (ce && mode == ST_NORMAL && !drive_on) |=>
            y_neg_plate_on && !x_pos_plate_on && !x_neg_plate_on &&
            !y_pos_plate_on;
    endproperty
    a_idle_yn: assert property (p_idle_yn)
        else $error("idle switches wrong");

    property p_pd_irq;
        @(posedge clk) disable iff (srst)
        (ce && mode == ST_NORMAL && pd) |=>
            pen_touch_irq_n_oe && !pen_touch_irq_n_out;
    endproperty
    a_pd_irq: assert property (p_pd_irq)
        else $error("irq not low with pd set");

    property p_pen_follow;
        @(posedge clk) disable iff (srst)
        (ce && mode == ST_NORMAL && !pd && !busy) |=>
            pen_touch_irq_n_out == !$past(pen_s);
    endproperty
    a_pen_follow: assert property (p_pen_follow)
        else $error("irq does not follow pen");

    property p_fields;
        @(posedge clk) disable iff (srst)
        (ce && apply_evt && cmd_byte[BIT_CLASS]) |=>
            sel == $past(cmd_byte[BIT_SEL_HI:BIT_SEL_LO]) &&
            pd == $past(cmd_byte[BIT_PD]) && res == $past(cmd_byte[BIT_RES]);
    endproperty
    a_fields: assert property (p_fields)
        else $error("command fields not taken");

    property p_accel;
        @(posedge clk) disable iff (srst)
        (ce && apply_evt && cmd_byte[BIT_CLASS] &&
         !cmd_byte[BIT_SEL_HI] && mode == ST_NORMAL) ##1 ce |=>
            {x_pos_plate_on, x_neg_plate_on, y_pos_plate_on,
             y_neg_plate_on} == tcd_switches($past(sel[1:0]));
    endproperty
    a_accel: assert property (p_accel)
        else $error("accelerate drive missing");

    property p_sleep_entry;
        @(posedge clk) disable iff (srst)
        (ce && sleep_evt && tcd_is_sleep(sleep_byte)) |=> mode == ST_SLEEP;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("sleep not entered");

    property p_axis_power;
        @(posedge clk) disable iff (srst)
        (ce && mode == ST_NORMAL && pd && axis_sel) |=> conv_power;
    endproperty
    a_axis_power: assert property (p_axis_power)
        else $error("converter power dropped");

    property p_format12;
        @(posedge clk) disable iff (srst)
        (ce && adc_done && !res) |=>
            read_word == {$past(adc_result), PAD_ZERO};
    endproperty
    a_format12: assert property (p_format12)
        else $error("12-bit format wrong");

endmodule : tcd_touch_ctrl

// ### logic/tcd_pkg.sv
// Purpose: Shared constants, types and decode helpers for the touch
//          command decoder and power control block.
// Assumes: Command byte layout class/selector/pd/resolution, MSB first.
// Notes:   Edge counts are numbered from the first SCL edge of a frame.
package tcd_pkg;

    // Command byte layout
    localparam int CMD_W = 8;
    localparam int SEL_W = 3;
    localparam int BIT_CLASS = 7;
    localparam int BIT_SEL_HI = 6;
    localparam int BIT_SEL_LO = 4;
    localparam int BIT_PD = 2;
    localparam int BIT_RES = 1;
    localparam logic [SEL_W-1:0] SEL_SLEEP = 3'h7;
    localparam logic [SEL_W-1:0] SEL_X_AXIS = 3'h4;
    localparam logic [SEL_W-1:0] SEL_Y_AXIS = 3'h5;

    // Values held after reset: X axis, auto power-down, 12-bit
    localparam logic [SEL_W-1:0] RST_SEL = 3'h4;
    localparam logic RST_PD = 1'b0;
    localparam logic RST_RES = 1'b0;

    // Measurement pairs (low two selector bits)
    localparam logic [1:0] PAIR_X = 2'h0;
    localparam logic [1:0] PAIR_Y = 2'h1;
    localparam logic [1:0] PAIR_Z1 = 2'h2;
    localparam logic [1:0] PAIR_Z2 = 2'h3;

    // Switch sets, order {xp, xn, yp, yn}
    localparam logic [3:0] SW_X_DRIVE = 4'hc;
    localparam logic [3:0] SW_Y_DRIVE = 4'h3;
    localparam logic [3:0] SW_Z_DRIVE = 4'h6;
    localparam logic [3:0] SW_IDLE = 4'h1;
    localparam logic [3:0] SW_OPEN = 4'h0;

    // SCL edge numbers within a frame
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;
    localparam logic [CNT_W-1:0] RISE_CMD_FIRST = 5'h0a;
    localparam logic [CNT_W-1:0] RISE_SLEEP = 5'h10;
    localparam logic [CNT_W-1:0] RISE_CMD_LAST = 5'h11;
    localparam logic [CNT_W-1:0] FALL_SAMPLE = 5'h07;
    localparam logic [CNT_W-1:0] FALL_APPLY = 5'h12;
    localparam logic [CNT_W-1:0] FALL_CONV_END = 5'h15;

    // Result formatting
    localparam int RES_W = 12;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam logic [3:0] PAD_ZERO = 4'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    typedef enum logic [1:0] {NODE_XP, NODE_XN, NODE_YP, NODE_YN} tcd_node_t;
    typedef enum logic {ST_NORMAL, ST_SLEEP} tcd_mode_t;

    function automatic logic [3:0] tcd_switches(input logic [1:0] pair);
        logic [3:0] sw;
        sw = SW_Z_DRIVE;
        case (pair)
            PAIR_X: sw = SW_X_DRIVE;
            PAIR_Y: sw = SW_Y_DRIVE;
            default: sw = SW_Z_DRIVE;
        endcase
        return sw;
    endfunction : tcd_switches

    function automatic logic tcd_is_sleep(input logic [CMD_W-1:0] cmd);
        return !cmd[BIT_CLASS] && cmd[BIT_SEL_HI:BIT_SEL_LO] == SEL_SLEEP;
    endfunction : tcd_is_sleep

endpackage : tcd_pkg

// ### logic/tcd_link_capture.sv
// Purpose: SCL-domain capture of the command byte and frame timing.
// Assumes: Frame qualifiers come from a framer clocked by the same SCL and
//          drop for at least one full SCL cycle (a rising and a falling edge) between frames.
// Notes:   Held bytes stay stable long after their toggle flips.
`timescale 1ns/1ps
module tcd_link_capture (
    // Link clock and frame qualifiers
    input wire logic scl,
    input wire logic srst,
    input wire logic write_frame,
    input wire logic read_frame,
    input wire logic sda_in,
    // Toward the system clock domain
    output logic [tcd_pkg::CMD_W-1:0] sleep_byte,
    output logic sleep_tgl,
    output logic [tcd_pkg::CMD_W-1:0] cmd_byte,
    output logic apply_tgl,
    output logic conv_busy
);
    import tcd_pkg::*;

    logic rst_meta;
    logic link_rst;
    logic in_frame;
    logic [CNT_W-1:0] rise_cnt;
    logic [CNT_W-1:0] fall_cnt;
    logic [CNT_W-1:0] rise_num;
    logic [CNT_W-1:0] fall_num;
    logic [CMD_W-1:0] shift;

    assign in_frame = write_frame | read_frame;
    assign rise_num = rise_cnt + 1'b1;
    assign fall_num = fall_cnt + 1'b1;

    // Reset only reaches this domain while SCL runs
    always_ff @(posedge scl) begin
        rst_meta <= srst;
        link_rst <= rst_meta;
    end

    always_ff @(posedge scl) begin
        if (link_rst || !in_frame) begin
            rise_cnt <= '0;
        end else if (rise_cnt != CNT_MAX) begin
            rise_cnt <= rise_num;
        end
    end

    always_ff @(negedge scl) begin
        if (link_rst || !in_frame) begin
            fall_cnt <= '0;
        end else if (fall_cnt != CNT_MAX) begin
            fall_cnt <= fall_num;
        end
    end

    // Command bits shift in on rising SCL, MSB first
    always_ff @(posedge scl) begin
        if (link_rst) begin
            shift <= '0;
        end else if (write_frame && rise_num >= RISE_CMD_FIRST &&
                     rise_num <= RISE_CMD_LAST) begin
            shift <= {shift[CMD_W-2:0], sda_in};
        end
    end

    // Sleep decision needs bits 7..1 only, so it is taken early
    always_ff @(posedge scl) begin
        if (link_rst) begin
            sleep_byte <= '0;
            sleep_tgl <= 1'b0;
        end else if (write_frame && rise_num == RISE_SLEEP) begin
            sleep_byte <= {shift[CMD_W-3:0], sda_in, 1'b0};
            sleep_tgl <= ~sleep_tgl;
        end
    end

    always_ff @(posedge scl) begin
        if (link_rst) begin
            cmd_byte <= '0;
        end else if (write_frame && rise_num == RISE_CMD_LAST) begin
            cmd_byte <= {shift[CMD_W-2:0], sda_in};
        end
    end

    always_ff @(negedge scl) begin
        if (link_rst) begin
            apply_tgl <= 1'b0;
        end else if (write_frame && fall_num == FALL_APPLY) begin
            apply_tgl <= ~apply_tgl;
        end
    end

    // Sample and conversion run inside the read frame
    always_ff @(negedge scl) begin
        if (link_rst || !read_frame) begin
            conv_busy <= 1'b0;
        end else if (fall_num == FALL_SAMPLE) begin
            conv_busy <= 1'b1;
        end else if (fall_num == FALL_CONV_END) begin
            conv_busy <= 1'b0;
        end
    end

endmodule : tcd_link_capture

// ### sim/tcd_host_model.sv
// Purpose: Host side of the link: clocks command writes and read frames.
// Assumes: Link clock period 80 ns; it stands low outside frames.
// Notes:   Data line goes high through its pull-up whenever released.
`timescale 1ns/1ps
module tcd_host_model (
    // Link toward the device
    output logic scl,
    output logic sda_in,
    output logic write_frame,
    output logic read_frame
);
    initial begin
        scl = 1'b0;
        sda_in = 1'b1;
        write_frame = 1'b0;
        read_frame = 1'b0;
    end

    // Data and qualifiers only move while the clock is low
    task automatic pulse();
        #40 scl = ~scl;
        #40 scl = ~scl;
    endtask : pulse

    // Frames low, so the device clears its edge count between frames
    task automatic idle_clocks(input int n);
        repeat (n) pulse();
    endtask : idle_clocks

    task automatic write_cmd(input logic [7:0] cmd);
        write_frame = 1'b1;
        for (int k = 1; k <= 19; k++) begin
            sda_in = (k >= 10 && k <= 17) ? cmd[17-k] : 1'b1;
            pulse();
        end
        sda_in = 1'b1;
        write_frame = 1'b0;
        pulse();
    endtask : write_cmd

    // Sampling and conversion fall inside this frame
    task automatic read_conv();
        read_frame = 1'b1;
        repeat (22) pulse();
        read_frame = 1'b0;
        pulse();
    endtask : read_conv
endmodule : tcd_host_model

// ### sim/tb_top.sv
// Purpose: Self-checking bench for the touch command decoder.
// Assumes: Host model drives the link; bench drives the clk-domain pins.
// Notes:   Outputs are judged well after the crossing latency settles.
`timescale 1ns/1ps
module tb_top;
    import tcd_pkg::*;
    logic clk, srst, ce, pen_touched, adc_done;
    logic [RES_W-1:0] adc_result;
    logic scl, sda_in, write_frame, read_frame;
    logic xp, xn, yp, yn, conv_power, res8, irq_out, irq_oe;
    tcd_node_t in_p, in_n, r_p, r_n;
    logic [WORD_W-1:0] read_word;
    int n_errors = 0;
    int comparisons = 0;

    tcd_touch_ctrl u_tcd_touch_ctrl (
        .clk(clk), .srst(srst), .ce(ce), .scl(scl), .sda_in(sda_in),
        .write_frame(write_frame), .read_frame(read_frame),
        .pen_touched(pen_touched), .adc_result(adc_result),
        .adc_done(adc_done), .x_pos_plate_on(xp), .x_neg_plate_on(xn),
        .y_pos_plate_on(yp), .y_neg_plate_on(yn),
        .conv_input_pos(in_p), .conv_input_neg(in_n), .ref_pos(r_p),
        .ref_neg(r_n), .conv_power(conv_power), .resolution_8bit(res8),
        .read_word(read_word), .pen_touch_irq_n_out(irq_out),
        .pen_touch_irq_n_oe(irq_oe)
    );
    tcd_host_model u_tcd_host_model (
        .scl(scl), .sda_in(sda_in), .write_frame(write_frame),
        .read_frame(read_frame)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic final_report();
        if (n_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    // Switch set in the order {xp, xn, yp, yn}
    task automatic chk_sw(input logic [3:0] exp);
        chk_val({12'h000, xp, xn, yp, yn}, {12'h000, exp});
    endtask : chk_sw

    task automatic chk_bit(input logic got, input logic exp);
        chk_val({15'h0000, got}, {15'h0000, exp});
    endtask : chk_bit

    function automatic logic [7:0] exp_nodes(input logic [1:0] p);
        case (p)
            2'h0: return {NODE_YP, NODE_XN, NODE_XP, NODE_XN};
            2'h1: return {NODE_XP, NODE_YN, NODE_YP, NODE_YN};
            2'h2: return {NODE_XP, NODE_XN, NODE_YP, NODE_XN};
            default: return {NODE_YN, NODE_XN, NODE_YP, NODE_XN};
        endcase
    endfunction : exp_nodes

    task automatic settle();
        repeat (12) @(negedge clk);
    endtask : settle

    task automatic adc_pulse(input logic [11:0] r, input logic [15:0] exp);
        adc_result = r;
        adc_done = 1'b1;
        @(negedge clk);
        adc_done = 1'b0;
        @(negedge clk);
        chk_val(read_word, exp);
    endtask : adc_pulse

    // Judge the drive state mid-conversion, then the idle state after
    task automatic read_check(input logic [3:0] exp_sw);
        fork
            u_tcd_host_model.read_conv();
            begin
                #1200;
                chk_sw(exp_sw);
                chk_bit(conv_power, 1'b1);
                chk_bit(irq_out, 1'b0);
            end
        join
        settle();
        chk_sw(4'h1);
        chk_bit(conv_power, 1'b0);
    endtask : read_check

    task automatic t_reset_idle();
        chk_sw(4'h1);
        chk_bit(conv_power, 1'b0);
        for (int lvl = 1; lvl >= 0; lvl--) begin
            pen_touched = lvl[0];
            settle();
            chk_bit(irq_out, !lvl[0]);
        end
    endtask : t_reset_idle

    // Converter-on mode for selectors 4 to 7, ignored bits set high
    task automatic t_axis_pd();
        logic [2:0] s;
        for (int i = 4; i < 8; i++) begin
            s = 3'(i);
            u_tcd_host_model.write_cmd({1'b1, s, 2'b11, s[0], 1'b1});
            settle();
            chk_sw(s[1] ? 4'h6 : (s[0] ? 4'h3 : 4'hc));
            chk_val({8'h00, in_p, in_n, r_p, r_n},
                    {8'h00, exp_nodes(s[1:0])});
            chk_bit(conv_power, !s[1]);
            chk_bit(res8, s[0]);
            chk_val({14'h0000, irq_out, irq_oe}, 16'h0001);
        end
        adc_pulse(12'habc, 16'hab00);
    endtask : t_axis_pd

    task automatic t_auto_read();
        u_tcd_host_model.write_cmd(8'hc9);
        settle();
        chk_sw(4'h1);
        chk_bit(res8, 1'b0);
        read_check(4'hc);
        adc_pulse(12'h5a3, 16'h5a30);
    endtask : t_auto_read

    // Accelerate closes switches right after the write, long before a read
    task automatic t_accel();
        u_tcd_host_model.write_cmd(8'h90);
        settle();
        chk_sw(4'h3);
        read_check(4'h3);
        u_tcd_host_model.write_cmd(8'ha4);
        settle();
        chk_sw(4'h6);
        chk_bit(conv_power, 1'b0);
    endtask : t_accel

    task automatic t_sleep();
        u_tcd_host_model.write_cmd(8'h72);
        settle();
        chk_sw(4'h0);
        chk_bit(irq_oe, 1'b0);
        u_tcd_host_model.write_cmd(8'h70);
        settle();
        chk_val({14'h0000, irq_out, irq_oe}, 16'h0003);
        chk_sw(4'h0);
        u_tcd_host_model.write_cmd(8'hd0);
        settle();
        chk_sw(4'h1);
        // Class bit clear, selector not sleep: nothing may change
        u_tcd_host_model.write_cmd(8'h46);
        settle();
        chk_bit(res8, 1'b0);
        read_check(4'h3);
    endtask : t_sleep

    // Enable low freezes the decode; the pending command lands on resume
    task automatic t_ce_freeze();
        ce = ~ce;
        u_tcd_host_model.write_cmd(8'h94);
        settle();
        chk_sw(4'h1);
        chk_bit(irq_out, 1'b1);
        ce = ~ce;
        settle();
        chk_sw(4'h3);
        chk_bit(irq_out, 1'b0);
        chk_bit(conv_power, 1'b0);
    endtask : t_ce_freeze

    initial begin
        #200000;
        n_errors++;
        final_report();
    end

    initial begin
        srst = 1'b1;
        ce = 1'b1;
        pen_touched = 1'b0;
        adc_done = 1'b0;
        adc_result = 12'h000;
        // The link side needs several of its own edges inside reset
        fork
            repeat (5) @(negedge clk);
            u_tcd_host_model.idle_clocks(4);
        join
        @(negedge clk);
        srst = 1'b0;
        u_tcd_host_model.idle_clocks(3);
        settle();
        t_reset_idle();
        t_axis_pd();
        t_auto_read();
        t_accel();
        t_sleep();
        t_ce_freeze();
        final_report();
    end
endmodule : tb_top
